// >>> shared/psa_pkg.sv
// Shared constants of the program space access unit.
package psa_pkg;

    // Address and data widths
    localparam int PROG_ADDR_W = 24;
    localparam int PROG_DATA_W = 24;
    localparam int DATA_W      = 16;
    localparam int PAGE_W      = 8;

    // Field positions
    localparam int CFG_SPACE_BIT = 7;      // Table page bit picking configuration space
    localparam int VIS_EN_BIT    = 2;      // Visibility enable in core control
    localparam int TRIGGER_BIT   = 15;     // Flash operation trigger in flash control
    localparam int ERASE_BIT     = 6;      // Erase select in flash control
    localparam int EA_MSB        = 15;
    localparam int VIS_LOW_W     = 15;

    // Array geometry, in instructions, rows and bytes
    localparam int ROW_INSTR     = 64;
    localparam int PAGE_ROWS     = 8;
    localparam int ROW_BYTES     = 192;
    localparam int PAGE_BYTES    = 1536;

    // Register map on the plain register port
    localparam logic [3:0] REG_TABLE_PAGE = 4'h0;
    localparam logic [3:0] REG_VIS_PAGE   = 4'h1;
    localparam logic [3:0] REG_CORE_CTRL  = 4'h2;
    localparam logic [3:0] REG_FLASH_CTRL = 4'h3;
    localparam logic [3:0] REG_FLASH_KEY  = 4'h4;
    localparam logic [3:0] REG_STATUS     = 4'h5;

    // Unlock keys
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;

    // Reset values
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [7:0]  PAGE_RESET = 8'h00;

    // Cycle costs of a visibility access and a table write
    localparam logic [1:0] VIS_EXTRA_MOVE  = 2'h1;
    localparam logic [1:0] VIS_EXTRA_OTHER = 2'h2;
    localparam logic [1:0] TBL_WRITE_COST  = 2'h2;

    // Core operation codes
    typedef enum logic [2:0] {
        PSA_OP_NONE,
        PSA_OP_RD_LOW,
        PSA_OP_RD_HIGH,
        PSA_OP_WT_LOW,
        PSA_OP_WT_HIGH,
        PSA_OP_DATA_RD
    } psa_op_t;

endpackage

// >>> src/psa_access_unit.sv
// Program space access unit: table access, visibility window and row buffers.
// Notes on behaviour
// RULE1 - Word low read: bits 15..0
// RULE2 - Byte low read: select bit picks byte
// RULE3 - Word high read: 23..16, upper zero
// RULE4 - Byte high read: phantom reads zero
// RULE5 - Upper byte by high ops only
// RULE6 - Table address: page then address
// RULE7 - Page bit 7 picks configuration space
// RULE8 - Two addresses per program word
// RULE9 - Window needs address MSB and enable
// RULE10 - Window page gives upper bits
// RULE11 - Window: low word, two fetches
// RULE12 - No window during table work
// RULE13 - Window adds one or two cycles
// RULE14 - Repeat loop: two cycles at edges
// RULE15 - Rows of 64, pages of 8 rows
// RULE16 - Rows and pages aligned from zero
// RULE17 - 64-word buffers, loaded in order
// RULE18 - Core fills 64 pairs, then triggers
// RULE19 - Table write: two cycles, buffer only
// RULE20 - Array changes only when programming
// RULE21 - Window bit 15 from page bit 0
// RULE22 - Trigger starts, clears when done
// RULE23 - Core stalls until done
// RULE24 - Unlock keys precede start
// RULE25 - Buffers kept until row programmed
// RULE26 - Table read answers within instruction
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module psa_access_unit #(
    parameter int ROW_INSTR = psa_pkg::ROW_INSTR
) (
    // Clock and reset
    input  wire logic                    i_clk,
    input  wire logic                    i_rst,
    // Register port
    input  wire logic [3:0]              i_reg_addr,
    input  wire logic [15:0]             i_reg_wdata,
    input  wire logic                    i_reg_wr,
    input  wire logic                    i_reg_rd,
    output logic      [15:0]             o_reg_rdata,
    // Core operation request
    input  wire psa_pkg::psa_op_t        i_op,
    input  wire logic                    i_byte_mode,
    input  wire logic [15:0]             i_eff_addr,
    input  wire logic [15:0]             i_wdata,
    input  wire logic                    i_move_instr,
    input  wire logic                    i_in_repeat,
    input  wire logic                    i_repeat_edge,
    // Core answers
    output logic      [15:0]             o_rdata,
    output logic                         o_rvalid,
    output logic                         o_data_is_prog,
    output logic      [1:0]              o_extra_cycles,
    output logic                         o_stall,
    // Flash array side
    output logic      [23:0]             o_fl_addr,
    output logic                         o_fl_rd,
    input  wire logic [23:0]             i_fl_rdata,
    output logic                         o_fl_prog,
    output logic                         o_fl_erase,
    output logic      [23:0]             o_fl_wdata,
    output logic                         o_fl_cfg_space,
    input  wire logic                    i_fl_done
);

    localparam int IDX_W = $clog2(ROW_INSTR);

    // Elaboration-time check on the row size
    if (ROW_INSTR < 2 || (ROW_INSTR & (ROW_INSTR - 1)) != 0) begin : g_chk
        $error("ROW_INSTR must be a power of two of at least 2");
    end

    typedef enum logic [2:0] {
        PSA_ST_IDLE,
        PSA_ST_TBL_RD,
        PSA_ST_VIS_RD1,
        PSA_ST_VIS_RD2,
        PSA_ST_PROG_LOAD,
        PSA_ST_PROG_WAIT
    } psa_state_t;

    typedef struct packed {
        psa_state_t        st;
        logic [7:0]        tbl_page;
        logic [7:0]        vis_page;
        logic [15:0]       core_ctrl;
        logic [15:0]       fl_ctrl;

        logic              key_armed;
        logic              unlocked;

        logic [IDX_W-1:0]  load_idx;
        logic              buf_full;

        logic              rd_high;
        logic              rd_byte;
        logic              rd_sel;
        logic [IDX_W-1:0]  prog_idx;

        logic [15:0]       reg_rdata;
        logic [15:0]       rdata;
        logic              rvalid;
        logic              data_is_prog;
        logic [1:0]        extra;
        logic              stall;

        logic [23:0]       fl_addr;
        logic              fl_rd;
        logic              fl_prog;
        logic              fl_erase;
        logic [23:0]       fl_wdata;
        logic              fl_cfg;
        logic [23:0]       row_base;
    } psa_regs_t;

    psa_regs_t q, d;

    // Row holding buffers, one 24-bit word per instruction
    logic [23:0] hold_mem [ROW_INSTR];
    logic        hold_we;
    logic [IDX_W-1:0] hold_widx;
    logic [23:0] hold_wval;

    logic [23:0] tbl_addr;
    logic [23:0] vis_addr;
    logic        vis_hit;
    logic        is_table;

    // Address formation for both access paths
    always_comb begin
        tbl_addr = {q.tbl_page, i_eff_addr};                              // [RULE6] [RULE8]
        vis_addr = {1'b0, q.vis_page, i_eff_addr[psa_pkg::VIS_LOW_W-1:0]}; // [RULE10] [RULE21]
        is_table = i_op inside {psa_pkg::PSA_OP_RD_LOW, psa_pkg::PSA_OP_RD_HIGH,
                                psa_pkg::PSA_OP_WT_LOW, psa_pkg::PSA_OP_WT_HIGH};

        // Table work in flight holds the window off
        vis_hit  = (i_op == psa_pkg::PSA_OP_DATA_RD) && i_eff_addr[psa_pkg::EA_MSB] &&
                   q.core_ctrl[psa_pkg::VIS_EN_BIT] && (q.st == PSA_ST_IDLE);  // [RULE9] [RULE12]
    end

    // Next-state logic for the whole unit
    always_comb begin
        d          = q;
        d.rvalid   = 1'b0;
        d.fl_rd    = 1'b0;
        d.fl_prog  = 1'b0;
        d.fl_erase = 1'b0;
        d.reg_rdata = 16'h0000;
        d.extra    = 2'h0;
        d.data_is_prog = 1'b0;

        hold_we    = 1'b0;
        hold_widx  = q.load_idx;
        hold_wval  = 24'h000000;

        // Register reads
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                psa_pkg::REG_TABLE_PAGE: d.reg_rdata = {8'h00, q.tbl_page};
                psa_pkg::REG_VIS_PAGE:   d.reg_rdata = {8'h00, q.vis_page};
                psa_pkg::REG_CORE_CTRL:  d.reg_rdata = q.core_ctrl;
                psa_pkg::REG_FLASH_CTRL: d.reg_rdata = q.fl_ctrl;
                psa_pkg::REG_STATUS:     d.reg_rdata = {q.buf_full, 15'(q.load_idx)};
                default:                 d.reg_rdata = 16'h0000;
            endcase
        end

        // Register writes; key register is write only
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                psa_pkg::REG_TABLE_PAGE: d.tbl_page = i_reg_wdata[7:0];
                psa_pkg::REG_VIS_PAGE:   d.vis_page = i_reg_wdata[7:0];
                psa_pkg::REG_CORE_CTRL:  d.core_ctrl = i_reg_wdata;

                psa_pkg::REG_FLASH_CTRL: begin
                    d.fl_ctrl = {q.fl_ctrl[psa_pkg::TRIGGER_BIT], i_reg_wdata[14:0]};
                    // Trigger only accepted after the unlock pair
                    if (i_reg_wdata[psa_pkg::TRIGGER_BIT] && q.unlocked &&
                        q.st == PSA_ST_IDLE) begin                          // [RULE24]
                        d.fl_ctrl[psa_pkg::TRIGGER_BIT] = 1'b1;            // [RULE22]
                        d.st       = PSA_ST_PROG_LOAD;
                        d.prog_idx = '0;
                        d.stall    = 1'b1;                                  // [RULE23]
                    end
                    d.unlocked = 1'b0;
                end

                psa_pkg::REG_FLASH_KEY: begin
                    d.key_armed = (i_reg_wdata[7:0] == psa_pkg::KEY_FIRST);
                    d.unlocked  = q.key_armed && (i_reg_wdata[7:0] == psa_pkg::KEY_SECOND);
                end

                default: ;
            endcase
        end

        unique case (q.st)
            PSA_ST_IDLE: begin
                if (is_table) begin
                    d.fl_addr = tbl_addr;
                    d.fl_cfg  = tbl_addr[16 + psa_pkg::CFG_SPACE_BIT];      // [RULE7]
                end

                if (i_op == psa_pkg::PSA_OP_RD_LOW || i_op == psa_pkg::PSA_OP_RD_HIGH) begin
                    d.fl_rd   = 1'b1;
                    d.rd_high = (i_op == psa_pkg::PSA_OP_RD_HIGH);
                    d.rd_byte = i_byte_mode;
                    d.rd_sel  = i_eff_addr[0];
                    d.st      = PSA_ST_TBL_RD;
                end else if (is_table) begin
                    // Writes land in the holding buffer only, never the array
                    hold_we   = !q.buf_full;                                // [RULE19] [RULE20]
                    hold_widx = i_eff_addr[IDX_W:1];                        // [RULE17]
                    hold_wval = hold_mem[hold_widx];
                    if (i_op == psa_pkg::PSA_OP_WT_HIGH) begin
                        if (i_byte_mode) begin
                            if (!i_eff_addr[0]) hold_wval[23:16] = i_wdata[7:0];
                        end else begin
                            hold_wval[23:16] = i_wdata[7:0];                // [RULE5]
                        end
                    end else if (i_byte_mode) begin
                        if (i_eff_addr[0]) hold_wval[15:8] = i_wdata[7:0];
                        else hold_wval[7:0] = i_wdata[7:0];
                    end else begin
                        hold_wval[15:0] = i_wdata;
                    end

                    // Row base is aligned on a 64-word boundary
                    d.row_base = {tbl_addr[23:IDX_W+1], {(IDX_W+1){1'b0}}}; // [RULE16]
                    if (i_op == psa_pkg::PSA_OP_WT_HIGH && !q.buf_full) begin
                        d.load_idx = q.load_idx + 1'b1;
                        d.buf_full = (q.load_idx == IDX_W'(ROW_INSTR - 1));
                    end
                    d.extra = psa_pkg::TBL_WRITE_COST;
                end else if (vis_hit) begin
                    d.fl_addr = vis_addr;
                    d.fl_cfg  = 1'b0;
                    d.fl_rd   = 1'b1;
                    d.st      = PSA_ST_VIS_RD1;
                    // Extra cycle cost depends on repeat context
                    if (i_in_repeat && !i_repeat_edge) d.extra = 2'h0;      // [RULE14]
                    else if (i_in_repeat) d.extra = psa_pkg::VIS_EXTRA_OTHER;
                    else if (i_move_instr) d.extra = psa_pkg::VIS_EXTRA_MOVE;     // [RULE13]
                    else d.extra = psa_pkg::VIS_EXTRA_OTHER;
                end
            end

            PSA_ST_TBL_RD: begin
                d.rvalid = 1'b1;                                            // [RULE26]
                d.st     = PSA_ST_IDLE;

                if (!q.rd_high && !q.rd_byte) d.rdata = i_fl_rdata[15:0];   // [RULE1]
                else if (!q.rd_high) d.rdata = {8'h00, q.rd_sel ?
                                         i_fl_rdata[15:8] : i_fl_rdata[7:0]};   // [RULE2]
                else if (!q.rd_byte) d.rdata = {8'h00, i_fl_rdata[23:16]};  // [RULE3]
                else d.rdata = {8'h00, q.rd_sel ? 8'h00 : i_fl_rdata[23:16]}; // [RULE4]
            end

            PSA_ST_VIS_RD1: begin
                d.fl_rd = 1'b1;                                             // [RULE11]
                d.st    = PSA_ST_VIS_RD2;
            end

            PSA_ST_VIS_RD2: begin
                d.rdata        = i_fl_rdata[15:0];                          // [RULE11]
                d.rvalid       = 1'b1;
                d.data_is_prog = 1'b1;
                d.st           = PSA_ST_IDLE;
            end

            PSA_ST_PROG_LOAD: begin
                d.fl_erase = q.fl_ctrl[psa_pkg::ERASE_BIT];                 // [RULE15]
                d.fl_prog  = !q.fl_ctrl[psa_pkg::ERASE_BIT];
                d.fl_addr  = q.row_base;
                d.fl_wdata = hold_mem[q.prog_idx];
                d.st       = PSA_ST_PROG_WAIT;
            end

            PSA_ST_PROG_WAIT: begin
                if (i_fl_done) begin
                    if (q.fl_ctrl[psa_pkg::ERASE_BIT] ||
                        q.prog_idx == IDX_W'(ROW_INSTR - 1)) begin
                        d.fl_ctrl[psa_pkg::TRIGGER_BIT] = 1'b0;             // [RULE22]
                        d.stall    = 1'b0;                                  // [RULE23]
                        d.buf_full = 1'b0;                                  // [RULE25]
                        d.load_idx = '0;
                        d.st       = PSA_ST_IDLE;
                    end else begin
                        d.prog_idx = q.prog_idx + 1'b1;
                        d.row_base = q.row_base + 24'h000002;               // [RULE8]
                        d.st       = PSA_ST_PROG_LOAD;
                    end
                end
            end
            default: d.st = PSA_ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q           <= '0;

            q.st        <= PSA_ST_IDLE;
            q.tbl_page  <= psa_pkg::PAGE_RESET;
            q.vis_page  <= psa_pkg::PAGE_RESET;
            q.core_ctrl <= psa_pkg::CTRL_RESET;
            q.fl_ctrl   <= psa_pkg::CTRL_RESET;
        end else begin
            q <= d;
        end
    end

    // Holding buffer writes; no reset so it maps to plain storage
    always_ff @(posedge i_clk) begin
        if (hold_we) begin
            hold_mem[hold_widx] <= hold_wval;                               // [RULE17]
        end
    end

    // Outputs straight from flip-flops
    assign o_reg_rdata    = q.reg_rdata;

    assign o_rdata        = q.rdata;
    assign o_rvalid       = q.rvalid;
    assign o_data_is_prog = q.data_is_prog;
    assign o_extra_cycles = q.extra;
    assign o_stall        = q.stall;

    assign o_fl_addr      = q.fl_addr;
    assign o_fl_rd        = q.fl_rd;
    assign o_fl_prog      = q.fl_prog;
    assign o_fl_erase     = q.fl_erase;
    assign o_fl_wdata     = q.fl_wdata;
    assign o_fl_cfg_space = q.fl_cfg;

endmodule

// >>> test/psa_access_monitor.sv
// Port checker bound to the program space access unit.
`timescale 1ns/100ps
module psa_access_monitor #(
    parameter int ROW_INSTR = 64
) (
    // Clock, reset and register side
    input wire logic             i_clk,
    input wire logic             i_rst,
    input wire logic [3:0]       i_reg_addr,
    input wire logic [15:0]      i_reg_wdata,
    input wire logic             i_reg_wr,
    // Core side
    input wire psa_pkg::psa_op_t i_op,
    input wire logic             i_byte_mode,
    input wire logic [15:0]      i_eff_addr,
    input wire logic             i_move_instr,
    input wire logic             i_in_repeat,
    input wire logic             i_repeat_edge,
    input wire logic [15:0]      o_rdata,
    input wire logic             o_rvalid,
    input wire logic             o_data_is_prog,
    input wire logic [1:0]       o_extra_cycles,
    input wire logic             o_stall,
    // Array side
    input wire logic [23:0]      o_fl_addr,
    input wire logic             o_fl_rd,
    input wire logic             o_fl_prog,
    input wire logic             o_fl_erase,
    input wire logic             o_fl_cfg_space
);
    logic [7:0] tp_q;
    logic [7:0] vp_q;
    logic       en_q;
    logic       tbl_rd;
    logic       win_rd;
    logic       wr_op;
    logic       dr_op;
    logic       rh_rd;
    // Shadow page and enable values, from the write port alone
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tp_q <= 8'h00;
            vp_q <= 8'h00;
            en_q <= 1'b0;
        end else if (i_reg_wr) begin
            if (i_reg_addr == psa_pkg::REG_TABLE_PAGE) tp_q <= i_reg_wdata[7:0];
            if (i_reg_addr == psa_pkg::REG_VIS_PAGE) vp_q <= i_reg_wdata[7:0];
            if (i_reg_addr == psa_pkg::REG_CORE_CTRL) en_q <= i_reg_wdata[psa_pkg::VIS_EN_BIT];
        end
    end
    // Requests that the unit must accept while idle
    assign tbl_rd = !o_stall && (i_op inside {psa_pkg::PSA_OP_RD_LOW, psa_pkg::PSA_OP_RD_HIGH});
    assign dr_op = !o_stall && i_op == psa_pkg::PSA_OP_DATA_RD;
    assign win_rd = dr_op && i_eff_addr[15] && en_q;
    assign rh_rd = tbl_rd && i_op == psa_pkg::PSA_OP_RD_HIGH;
    assign wr_op = !o_stall && (i_op inside {psa_pkg::PSA_OP_WT_LOW, psa_pkg::PSA_OP_WT_HIGH});
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_tbl; ##1 o_fl_rd ##1 o_rvalid; endsequence
    sequence s_win; ##1 o_fl_rd ##1 o_fl_rd ##1 (o_rvalid && o_data_is_prog); endsequence
    tbl_fetch_a: assert property (tbl_rd |-> s_tbl)
        else $error("table read late");
    tbl_addr_a: assert property (tbl_rd |=> o_fl_addr == {$past(tp_q), $past(i_eff_addr)}
        && o_fl_cfg_space == $past(tp_q[7])) else $error("table address wrong");
    win_fetch_a: assert property (win_rd |-> s_win)
        else $error("window fetches");
    win_addr_a: assert property (win_rd |=> o_fl_addr ==
        {1'b0, $past(vp_q), $past(i_eff_addr[14:0])}) else $error("window address wrong");
    win_off_a: assert property (dr_op && !(i_eff_addr[15] && en_q)
        |=> !o_data_is_prog [*3]) else $error("window misused");
    win_cost_a: assert property (win_rd && !i_in_repeat |=>
        o_extra_cycles == ($past(i_move_instr) ? 2'h1 : 2'h2)) else $error("window cost");
    loop_cost_a: assert property (win_rd && i_in_repeat && !i_move_instr |=>
        o_extra_cycles == ($past(i_repeat_edge) ? 2'h2 : 2'h0)) else $error("loop cost");
    write_cost_a: assert property (wr_op |=> o_extra_cycles == 2'h2 ##0 !o_fl_prog [*4])
        else $error("write cost or array hit");
    high_word_a: assert property (rh_rd && !i_byte_mode
        |-> ##2 o_rdata[15:8] == 8'h00) else $error("high byte not zero");
    phantom_a: assert property (rh_rd && i_byte_mode && i_eff_addr[0]
        |-> ##2 o_rdata[7:0] == 8'h00) else $error("phantom not zero");
    prog_stall_a: assert property (o_fl_prog || o_fl_erase |-> o_stall)
        else $error("no stall");
endmodule

bind psa_access_unit psa_access_monitor #(.ROW_INSTR(ROW_INSTR)) u_monitor (.*);

// >>> test/psa_flash_model.sv
// Flash array model with pattern reads and varied latency.
`timescale 1ns/100ps
module psa_flash_model (
    // Clock, reset and array requests
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic [23:0] i_addr,
    input  wire logic        i_rd,
    input  wire logic        i_prog,
    input  wire logic        i_erase,
    input  wire logic [23:0] i_wdata,
    // Answers and counts for the bench
    output logic      [23:0] o_rdata,
    output logic             o_done,
    output int               o_n_prog,
    output int               o_n_erase,
    output logic      [23:0] o_last_addr,
    output logic      [23:0] o_last_wdata
);
    logic [3:0] wait_q;
    // Answers within the fetch cycle; idle shows the inverse so late samples fail
    assign o_rdata = {24{~i_rd}} ^ {i_addr[7:0] ^ i_addr[23:16], i_addr[15:0] ^ 16'h5a96};
    // Latency and counts
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_done <= 1'b0;
            wait_q <= 4'h0;
            o_n_prog <= 0;
            o_n_erase <= 0;
            o_last_addr <= 24'h000000;
            o_last_wdata <= 24'h000000;
        end else begin
            o_done <= (wait_q == 4'h1);
            wait_q <= (wait_q != 4'h0) ? wait_q - 4'h1 : 4'h0;
            if (i_prog || i_erase) begin
                wait_q <= o_n_prog[0] ? 4'h9 : 4'h2; // Prompt and slow words alternate
            end
            if (i_prog) begin
                o_n_prog <= o_n_prog + 1;
                o_last_addr <= i_addr;
                o_last_wdata <= i_wdata;
            end
            if (i_erase) o_n_erase <= o_n_erase + 1;
        end
    end
endmodule

// >>> test/psa_access_unit_test.sv
// Self-checking bench for the program space access unit.
`timescale 1ns/100ps
module psa_access_unit_test;
    localparam psa_pkg::psa_op_t RL = psa_pkg::PSA_OP_RD_LOW;
    localparam psa_pkg::psa_op_t RH = psa_pkg::PSA_OP_RD_HIGH;
    localparam psa_pkg::psa_op_t DR = psa_pkg::PSA_OP_DATA_RD;
    logic             i_clk, i_rst, i_reg_wr, i_reg_rd, i_byte_mode, i_move_instr;
    logic             i_in_repeat, i_repeat_edge, o_rvalid, o_data_is_prog, o_stall;
    logic             o_fl_rd, o_fl_prog, o_fl_erase, o_fl_cfg_space, i_fl_done;
    logic [3:0]       i_reg_addr;
    logic [15:0]      i_reg_wdata, i_eff_addr, i_wdata, o_reg_rdata, o_rdata, rd_v;
    logic [1:0]       o_extra_cycles, ex_v;
    logic [23:0]      o_fl_addr, i_fl_rdata, o_fl_wdata, last_addr, last_wdata, p, q;
    psa_pkg::psa_op_t i_op;
    int               err_total, compares, cyc, n_prog, n_erase;

    psa_access_unit #(.ROW_INSTR(64)) DUT (.*);
    psa_flash_model u_flash (.i_clk, .i_rst, .i_addr(o_fl_addr), .i_rd(o_fl_rd),
        .i_prog(o_fl_prog), .i_erase(o_fl_erase), .i_wdata(o_fl_wdata), .o_rdata(i_fl_rdata),
        .o_done(i_fl_done), .o_n_prog(n_prog), .o_n_erase(n_erase), .o_last_addr(last_addr),
        .o_last_wdata(last_wdata));

    // Clock at 100 ns period
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    // Ceiling far above the ~2000 cycles needed
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end

    function automatic logic [23:0] pat(logic [23:0] a);
        return {a[7:0] ^ a[23:16], a[15:0] ^ 16'h5a96};
    endfunction
    task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [15:0] d);
        @(posedge i_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
    endtask
    task automatic rd(logic [3:0] a, logic [15:0] e, logic [15:0] m, string nm);
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        #1 chk(nm, e, o_reg_rdata & m);
    endtask
    // One core request; grabs cost and any answer in five cycles
    task automatic op(psa_pkg::psa_op_t o, logic [15:0] ea, logic [15:0] wd = 16'h0000,
        logic bm = 1'b0, logic mv = 1'b0);
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
        i_op <= o;
        i_eff_addr <= ea;
        i_wdata <= wd;
        i_byte_mode <= bm;
        i_move_instr <= mv;
        @(posedge i_clk);
        i_op <= psa_pkg::PSA_OP_NONE;
        #1 ex_v = o_extra_cycles;
        rd_v = 'x;
        repeat (5) begin
            if (o_rvalid === 1'b1) rd_v = o_rdata;
            @(posedge i_clk);
            #1;
        end
    endtask
    task automatic run_flash(logic [15:0] ctrl);
        wr(psa_pkg::REG_FLASH_KEY, {8'h00, psa_pkg::KEY_FIRST});
        wr(psa_pkg::REG_FLASH_KEY, {8'h00, psa_pkg::KEY_SECOND});
        wr(psa_pkg::REG_FLASH_CTRL, ctrl);
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
        #1 chk("stall", 1'b1, o_stall);
        for (int k = 0; k < 3000 && o_stall !== 1'b0; k++) @(posedge i_clk);
        #1 rd(psa_pkg::REG_FLASH_CTRL, 16'h0000, 16'h8000, "trigger");
    endtask

    task automatic t_regs;
        rd(psa_pkg::REG_TABLE_PAGE, 16'h0000, 16'hffff, "tpage reset");
        rd(psa_pkg::REG_CORE_CTRL, 16'h0000, 16'hffff, "corectl reset");
        wr(psa_pkg::REG_VIS_PAGE, 16'h0013);
        wr(4'hf, 16'hffff);
        rd(psa_pkg::REG_VIS_PAGE, 16'h0013, 16'h00ff, "vpage");
        rd(4'hf, 16'h0000, 16'hffff, "unmapped");
        rd(psa_pkg::REG_FLASH_KEY, 16'h0000, 16'hffff, "key");
        $display("register test done");
    endtask
    task automatic t_tblrd;
        wr(psa_pkg::REG_TABLE_PAGE, 16'h0081);
        p = pat(24'h811234);
        q = pat(24'h811235);
        op(RL, 16'h1234);
        chk("low word", p[15:0], rd_v);
        op(RL, 16'h1234, 16'h0000, 1'b1);
        chk("low byte0", p[7:0], rd_v[7:0]);
        op(RL, 16'h1235, 16'h0000, 1'b1);
        chk("low byte1", q[15:8], rd_v[7:0]);
        op(RH, 16'h1234);
        chk("high word", {8'h00, p[23:16]}, rd_v);
        op(RH, 16'h1234, 16'h0000, 1'b1);
        chk("high byte0", p[23:16], rd_v[7:0]);
        op(RH, 16'h1235, 16'h0000, 1'b1);
        chk("high phantom", 8'h00, rd_v[7:0]);
        $display("table read test done");
    endtask
    task automatic t_win;
        wr(psa_pkg::REG_CORE_CTRL, 16'h0004);
        p = pat({1'b0, 8'h13, 15'h0a5a});
        op(DR, 16'h8a5a, 16'h0000, 1'b0, 1'b1);
        chk("window data", p[15:0], rd_v);
        chk("move cost", psa_pkg::VIS_EXTRA_MOVE, ex_v);
        op(DR, 16'h8a5a);
        chk("other cost", psa_pkg::VIS_EXTRA_OTHER, ex_v);
        @(posedge i_clk);
        i_in_repeat <= 1'b1;
        i_repeat_edge <= 1'b1;
        op(DR, 16'h8a5a);
        chk("loop edge cost", 2'h2, ex_v);
        @(posedge i_clk);
        i_repeat_edge <= 1'b0;
        op(DR, 16'h8a5a);
        chk("loop body cost", 2'h0, ex_v);
        @(posedge i_clk);
        i_in_repeat <= 1'b0;
        op(DR, 16'h0a5a);
        wr(psa_pkg::REG_CORE_CTRL, 16'h0000);
        op(DR, 16'h8a5a);
        $display("window test done");
    endtask
    // Fill a row, overflow once, program, erase
    task automatic t_prog;
        wr(psa_pkg::REG_TABLE_PAGE, 16'h0002);
        for (int i = 0; i < 64; i++) begin
            op(psa_pkg::PSA_OP_WT_LOW, 16'h0180 + 16'(2 * i), 16'hc300 + 16'(i));
            op(psa_pkg::PSA_OP_WT_HIGH, 16'h0180 + 16'(2 * i), 16'h0040 + 16'(i));
        end
        chk("write cost", psa_pkg::TBL_WRITE_COST, ex_v);
        op(psa_pkg::PSA_OP_WT_LOW, 16'h01fe, 16'h0bad);
        rd(psa_pkg::REG_STATUS, 16'h8000, 16'h8000, "buffer full");
        chk("no early program", 24'h0, 24'(n_prog));
        run_flash(16'h8000);
        chk("words programmed", 24'(psa_pkg::ROW_INSTR), 24'(n_prog));
        chk("last address", {8'h02, 16'h01fe}, last_addr);
        chk("last word", 24'h7fc33f, last_wdata);
        rd(psa_pkg::REG_STATUS, 16'h0000, 16'h8000, "buffer freed");
        run_flash(16'h8040);
        chk("erases", 24'h1, 24'(n_erase));
        $display("programming test done");
    endtask

    task automatic end_of_test;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        {i_reg_wr, i_reg_rd, i_byte_mode, i_move_instr, i_in_repeat, i_repeat_edge} = 6'h00;
        {i_reg_addr, i_reg_wdata, i_eff_addr, i_wdata} = 52'h0;
        i_op = psa_pkg::PSA_OP_NONE;
        i_rst = 1'b1;
        err_total = 0;
        compares = 0;
        cyc = 0;
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        t_regs();
        t_tblrd();
        t_win();
        t_prog();
        end_of_test();
    end
endmodule
